// ---- hw/esoc_ctrl.sv ----
// status and override control register with auto-mask, edge select and alert
`timescale 1ns/1ps
// Contract
// [RQ1] override forces all PWM outputs to full
// [RQ2] read-clear mode: management bits clear on read
// [RQ3] otherwise management bits clear by writing one
// [RQ4] input four error masks all other events
// [RQ5] management bank frozen until its four flag clears
// [RQ6] host bank frozen until its four flag clears
// [RQ7] input five auto-mask behaves the same way
// [RQ8] edge field selects tach edges, 3 reserved
// [RQ9] host summary reads one when any host bit
// [RQ10] management summary reads one when any bit
// [RQ11] management summary with enable asserts alert
// [RQ12] alert only while alert enable is set
// [RQ13] lock blocks writes to read-clear mode bit
// [RQ14] writes to summary flags have no effect
module esoc_ctrl #(
  parameter int ERR_W = 8,
  parameter int TACH_N = 4,
  parameter int PWM_N = 2,
  parameter int PWM_W = 8
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic cfg_lock_i,
  input wire logic alert_enable_i,
  input wire logic general_input_four_i,
  input wire logic general_input_five_i,
  input wire logic [ERR_W-3:0] mgmt_event_i,
  input wire logic [ERR_W-3:0] host_event_i,
  input wire logic [TACH_N-1:0] tach_i,
  output logic [TACH_N-1:0] tach_pulse_o,
  input wire logic [PWM_N*PWM_W-1:0] pwm_auto_duty_i,
  output logic [PWM_N*PWM_W-1:0] pwm_duty_o,
  output logic alert_o
);

  // events allowed into a bank while an input auto-mask holds it
  function automatic logic [ERR_W-1:0] allow_mask(input logic [ERR_W-1:0] status, input logic am_four,
                                                   input logic am_five);
    logic hold_four;
    logic hold_five;
    hold_four = am_four & status[esoc_pkg::ERR_IN_FOUR];
    hold_five = am_five & status[esoc_pkg::ERR_IN_FIVE];
    allow_mask = '1;
    for (int i = 0; i < ERR_W; i++) begin
      if ((hold_four && i != esoc_pkg::ERR_IN_FOUR) || (hold_five && i != esoc_pkg::ERR_IN_FIVE)) begin
        allow_mask[i] = 1'b0;
      end
    end
  endfunction : allow_mask

  logic [5:0] ctrl;
  logic [5:0] next_ctrl;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic alert;
  logic next_alert;
  logic [PWM_N*PWM_W-1:0] duty;
  logic [PWM_N*PWM_W-1:0] next_duty;

  logic in_four;
  logic in_five;
  logic [1:0] edge_mode;
  logic override;
  logic read_clear;
  logic am_four;
  logic am_five;
  logic wr_ctrl;
  logic wr_mgmt;
  logic wr_host;
  logic rd_ctrl;
  logic rd_mgmt;
  logic [ERR_W-1:0] mgmt_evt;
  logic [ERR_W-1:0] host_evt;
  logic [ERR_W-1:0] mgmt_allow;
  logic [ERR_W-1:0] host_allow;
  logic [ERR_W-1:0] mgmt_clear;
  logic [ERR_W-1:0] host_clear;
  logic [ERR_W-1:0] mgmt_status;
  logic [ERR_W-1:0] host_status;
  logic mgmt_sum;
  logic host_sum;

  assign override = ctrl[esoc_pkg::BIT_PWM_OVERRIDE];
  assign read_clear = ctrl[esoc_pkg::BIT_READ_CLEAR];
  assign am_four = ctrl[esoc_pkg::BIT_AM_FOUR];
  assign am_five = ctrl[esoc_pkg::BIT_AM_FIVE];
  assign edge_mode = ctrl[esoc_pkg::BIT_EDGE_HI:esoc_pkg::BIT_EDGE_LO];

  assign wr_ctrl = reg_wr_i && reg_addr_i == esoc_pkg::ADDR_STATUS_CTRL;
  assign wr_mgmt = reg_wr_i && reg_addr_i == esoc_pkg::ADDR_MGMT_ERR;
  assign wr_host = reg_wr_i && reg_addr_i == esoc_pkg::ADDR_HOST_ERR;
  assign rd_ctrl = reg_rd_i && reg_addr_i == esoc_pkg::ADDR_STATUS_CTRL;
  assign rd_mgmt = reg_rd_i && reg_addr_i == esoc_pkg::ADDR_MGMT_ERR;

  // [RQ8] tach edge select
  for (genvar t = 0; t < TACH_N; t++) begin : g_tach
    esoc_tach_edge u_tach (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .sig_i(tach_i[t]),
      .mode_i(edge_mode),
      .level_o(),
      .pulse_o(tach_pulse_o[t])
    );
  end

  // input pins only need the synchronised level
  esoc_tach_edge u_in_four (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .sig_i(general_input_four_i),
    .mode_i(esoc_pkg::EDGE_RESERVED),
    .level_o(in_four),
    .pulse_o()
  );

  esoc_tach_edge u_in_five (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .sig_i(general_input_five_i),
    .mode_i(esoc_pkg::EDGE_RESERVED),
    .level_o(in_five),
    .pulse_o()
  );

  assign mgmt_evt = {mgmt_event_i, in_five, in_four};
  assign host_evt = {host_event_i, in_five, in_four};

  always_comb begin
    // [RQ4] auto-mask gating
    // [RQ5] management bank frozen
    // [RQ7] input five same
    mgmt_allow = allow_mask(mgmt_status, am_four, am_five);
    // [RQ6] host bank frozen
    host_allow = allow_mask(host_status, am_four, am_five);
    mgmt_clear = '0;
    // [RQ2] clear on read
    if (rd_mgmt && read_clear) begin
      mgmt_clear = mgmt_status;
    end
    // [RQ3] write one clears
    if (wr_mgmt && !read_clear) begin
      mgmt_clear = reg_wdata_i[ERR_W-1:0];
    end
    host_clear = wr_host ? reg_wdata_i[ERR_W-1:0] : '0;
  end

  esoc_err_bank #(
    .W(ERR_W)
  ) u_mgmt_bank (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .event_i(mgmt_evt),
    .allow_i(mgmt_allow),
    .clear_i(mgmt_clear),
    .status_o(mgmt_status)
  );

  esoc_err_bank #(
    .W(ERR_W)
  ) u_host_bank (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .event_i(host_evt),
    .allow_i(host_allow),
    .clear_i(host_clear),
    .status_o(host_status)
  );

  // [RQ9] host summary flag
  assign host_sum = |host_status;
  // [RQ10] management summary flag
  assign mgmt_sum = |mgmt_status;

  always_comb begin
    next_ctrl = ctrl;
    // [RQ14] summary bits not stored
    if (wr_ctrl) begin
      next_ctrl = reg_wdata_i[5:0] & esoc_pkg::CTRL_STORED_MASK;
      // [RQ13] lock holds read-clear
      if (cfg_lock_i) begin
        next_ctrl[esoc_pkg::BIT_READ_CLEAR] = read_clear;
      end
    end
    next_rdata = rdata;
    if (reg_rd_i) begin
      case (reg_addr_i)
        esoc_pkg::ADDR_STATUS_CTRL: next_rdata = {mgmt_sum, host_sum, ctrl};
        esoc_pkg::ADDR_MGMT_ERR: next_rdata = 8'(mgmt_status);
        esoc_pkg::ADDR_HOST_ERR: next_rdata = 8'(host_status);
        default: next_rdata = esoc_pkg::RDATA_UNMAPPED;
      endcase
    end
    // [RQ11] summary drives alert
    // [RQ12] alert gated by enable
    next_alert = mgmt_sum & alert_enable_i;
    // [RQ1] full duty override
    next_duty = override ? '1 : pwm_auto_duty_i;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl <= esoc_pkg::RST_STATUS_CTRL[5:0];
      rdata <= esoc_pkg::RST_RDATA;
      alert <= 1'b0;
      duty <= '0;
    end else begin
      ctrl <= next_ctrl;
      rdata <= next_rdata;
      alert <= next_alert;
      duty <= next_duty;
    end
  end

  assign reg_rdata_o = rdata;
  assign alert_o = alert;
  assign pwm_duty_o = duty;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  AST_PWM_OVERRIDE: assert property (override |=> pwm_duty_o == '1) // [RQ1]
    else $error("override did not force full duty");

  AST_READ_CLEAR: assert property ((rd_mgmt && read_clear && (mgmt_evt & mgmt_allow) == '0) // [RQ2]
    |=> mgmt_status == '0)
    else $error("management bits survived a clearing read");

  AST_W1C_ONLY: assert property (!(wr_mgmt && !read_clear) && !(rd_mgmt && read_clear) // [RQ3]
    |=> (mgmt_status & $past(mgmt_status)) == $past(mgmt_status))
    else $error("management bit fell without a clearing access");

  AST_MASK_FOUR_MGMT: assert property ((am_four && mgmt_status[esoc_pkg::ERR_IN_FOUR]) // [RQ5]
    |=> ((mgmt_status & ~$past(mgmt_status)) >> 1) == '0)
    else $error("management bank took an event while masked by input four");

  AST_MASK_FOUR_HOST: assert property ((am_four && host_status[esoc_pkg::ERR_IN_FOUR]) // [RQ6]
    |=> ((host_status & ~$past(host_status)) >> 1) == '0)
    else $error("host bank took an event while masked by input four");

  AST_MASK_FIVE_MGMT: assert property ((am_five && mgmt_status[esoc_pkg::ERR_IN_FIVE]) // [RQ7]
    |=> (mgmt_status & ~$past(mgmt_status) & ~(1 << esoc_pkg::ERR_IN_FIVE)) == '0)
    else $error("management bank took an event while masked by input five");

  // input four must land in both banks whenever the input five mask is off, with or without its own mask, so the mask can arm
  AST_AUTO_MASK_LOW: assert property ((!am_five && in_four) // [RQ4]
    |=> mgmt_status[esoc_pkg::ERR_IN_FOUR] && host_status[esoc_pkg::ERR_IN_FOUR])
    else $error("input four event was not recorded");

  AST_EDGE_RESERVED: assert property ((edge_mode == esoc_pkg::EDGE_RESERVED) [*2] // [RQ8]
    |-> tach_pulse_o == '0)
    else $error("tach pulse with reserved edge mode");

  AST_HOST_SUMMARY: assert property (rd_ctrl |=> reg_rdata_o[esoc_pkg::BIT_HOST_SUM] == $past(|host_status)) // [RQ9]
    else $error("host summary flag wrong");

  AST_MGMT_SUMMARY: assert property (rd_ctrl |=> reg_rdata_o[esoc_pkg::BIT_MGMT_SUM] == $past(|mgmt_status)) // [RQ10]
    else $error("management summary flag wrong");

  AST_ALERT_ON: assert property ((mgmt_sum && alert_enable_i) |=> alert_o) // [RQ11]
    else $error("alert missing");

  AST_ALERT_OFF: assert property (!alert_enable_i |=> !alert_o) // [RQ12]
    else $error("alert while disabled");

  AST_LOCKED_READ_CLEAR: assert property ((cfg_lock_i && wr_ctrl) |=> $stable(read_clear)) // [RQ13]
    else $error("locked read-clear bit changed");

  // a write of one to the host flag followed one idle cycle later by a read must still show it clear
  AST_SUMMARY_RO: assert property ((wr_ctrl && reg_wdata_i[esoc_pkg::BIT_HOST_SUM] && host_status == '0 // [RQ14]
    && host_evt == '0) ##1 (host_evt == '0) ##1 rd_ctrl |=> reg_rdata_o[esoc_pkg::BIT_HOST_SUM] == 1'b0)
    else $error("write reached a summary flag");

  COV_OVERRIDE: cover property (wr_ctrl ##1 override ##1 pwm_duty_o == '1);
  COV_READ_CLEAR: cover property (read_clear && mgmt_sum ##1 rd_mgmt ##1 !mgmt_sum);
  COV_AUTO_MASK: cover property (am_four && mgmt_status[esoc_pkg::ERR_IN_FOUR] && mgmt_event_i != '0);
  COV_ALERT: cover property (alert_enable_i && mgmt_sum ##1 alert_o);

endmodule : esoc_ctrl

// ---- shared/esoc_pkg.sv ----
// constants of the error status and override control register bank
package esoc_pkg;

  // register offsets on the internal register port
  localparam logic [7:0] ADDR_STATUS_CTRL = 8'he2;
  localparam logic [7:0] ADDR_MGMT_ERR = 8'h40;
  localparam logic [7:0] ADDR_HOST_ERR = 8'h41;

  // reset values and the unmapped read value
  localparam logic [7:0] RST_STATUS_CTRL = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // field positions of the status and override control register
  localparam int BIT_PWM_OVERRIDE = 0;
  localparam int BIT_READ_CLEAR = 1;
  localparam int BIT_AM_FOUR = 2;
  localparam int BIT_AM_FIVE = 3;
  localparam int BIT_EDGE_LO = 4;
  localparam int BIT_EDGE_HI = 5;
  localparam int BIT_HOST_SUM = 6;
  localparam int BIT_MGMT_SUM = 7;

  // bits that software can store; the two summary flags are live
  localparam logic [5:0] CTRL_STORED_MASK = 6'h3f;

  // positions of the two input error flags inside each error status bank
  localparam int ERR_IN_FOUR = 0;
  localparam int ERR_IN_FIVE = 1;

  // tachometer edge selection codes
  localparam logic [1:0] EDGE_EITHER = 2'h0;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_RESERVED = 2'h3;

endpackage : esoc_pkg

// ---- hw/esoc_tach_edge.sv ----
// two-flop synchroniser and selectable edge detector for one input pin
`timescale 1ns/1ps
module esoc_tach_edge (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic sig_i,
  input wire logic [1:0] mode_i,
  output logic level_o,
  output logic pulse_o
);

  logic meta;
  logic sync;
  logic prev;
  logic pulse;
  logic next_pulse;
  logic rise;
  logic fall;

  // the first stage feeds only the second stage
  always_comb begin
    rise = sync & ~prev;
    fall = ~sync & prev;
    case (mode_i)
      esoc_pkg::EDGE_EITHER: next_pulse = rise | fall;
      esoc_pkg::EDGE_RISING: next_pulse = rise;
      esoc_pkg::EDGE_FALLING: next_pulse = fall;
      default: next_pulse = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
      pulse <= 1'b0;
    end else begin
      meta <= sig_i;
      sync <= meta;
      prev <= sync;
      pulse <= next_pulse;
    end
  end

  assign level_o = sync;
  assign pulse_o = pulse;

endmodule : esoc_tach_edge

// ---- hw/esoc_err_bank.sv ----
// sticky error status bank with gated set and per-bit clear
`timescale 1ns/1ps
module esoc_err_bank #(
  parameter int W = 8
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] event_i,
  input wire logic [W-1:0] allow_i,
  input wire logic [W-1:0] clear_i,
  output logic [W-1:0] status_o
);

  logic [W-1:0] status;
  logic [W-1:0] next_status;

  // a set in the clearing cycle wins over the clear
  always_comb begin
    next_status = (status & ~clear_i) | (event_i & allow_i);
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  assign status_o = status;

endmodule : esoc_err_bank

// ---- dv/esoc_host_model.sv ----
// register port host model for the status and override control block
`timescale 1ns/1ps
module esoc_host_model (
  input wire logic clock_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // idle bus keeps changing so nothing can lean on a stale address
  task automatic idle();
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clock_i);
    idle();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clock_i);
    idle();
    d = reg_rdata_i;
  endtask : rd
  task automatic clr(input logic [7:0] a, input logic [7:0] m);
    wr(a, m);
  endtask : clr
endmodule : esoc_host_model

// ---- dv/esoc_ctrl_tb.sv ----
// self-checking bench of the status and override control block
`timescale 1ns/1ps
module esoc_ctrl_tb;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, alert;
  logic cfg_lock = 1'b0;
  logic alert_en = 1'b0;
  logic in_four = 1'b0;
  logic in_five = 1'b0;
  logic [5:0] mgmt_ev = 6'h00;
  logic [5:0] host_ev = 6'h00;
  logic [3:0] tach = 4'h0;
  logic [3:0] tach_pulse;
  logic [15:0] auto_duty = 16'h0000;
  logic [15:0] duty;
  int errors = 0;
  int samples_checked = 0;
  int pulses = 0;
  int mgmt_m, j;
  int tach_exp[4] = '{32, 16, 16, 0};

  always #5 clock_i = ~clock_i;

  esoc_ctrl esoc_ctrl_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .cfg_lock_i(cfg_lock),
    .alert_enable_i(alert_en), .general_input_four_i(in_four), .general_input_five_i(in_five),
    .mgmt_event_i(mgmt_ev), .host_event_i(host_ev), .tach_i(tach), .tach_pulse_o(tach_pulse),
    .pwm_auto_duty_i(auto_duty), .pwm_duty_o(duty), .alert_o(alert));

  esoc_host_model esoc_host_model_i (.clock_i(clock_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata));

  always @(posedge clock_i) pulses <= pulses + $countones(tach_pulse);

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    esoc_host_model_i.rd(a, d);
    chk(n, {8'h00, e}, {8'h00, d});
  endtask : rchk
  task automatic fire(input logic [5:0] m, input logic [5:0] h);
    @(negedge clock_i);
    mgmt_ev = m;
    host_ev = h;
    @(negedge clock_i);
    mgmt_ev = 6'h00;
    host_ev = 6'h00;
    @(negedge clock_i);
  endtask : fire
  task automatic end_sim();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // generous limit: the sequence needs a few hundred cycles
  initial begin
    #200000;
    errors++;
    end_sim();
  end

  initial begin
    void'($urandom(32'hf615));
    repeat (5) @(negedge clock_i);
    rst_b_i = 1'b1;
    rchk("ctrl_reset", esoc_pkg::ADDR_STATUS_CTRL, esoc_pkg::RST_STATUS_CTRL);
    esoc_host_model_i.wr(esoc_pkg::ADDR_STATUS_CTRL, 8'hff);
    rchk("ctrl_ro_flags", esoc_pkg::ADDR_STATUS_CTRL, 8'h3f);
    esoc_host_model_i.wr(esoc_pkg::ADDR_STATUS_CTRL, 8'h00);
    esoc_host_model_i.wr(8'h55, 8'hff);
    rchk("unmapped", 8'h55, esoc_pkg::RDATA_UNMAPPED);
    auto_duty = 16'($urandom);
    esoc_host_model_i.wr(esoc_pkg::ADDR_STATUS_CTRL, 8'h01);
    @(negedge clock_i);
    chk("duty_override", 16'hffff, duty);
    esoc_host_model_i.wr(esoc_pkg::ADDR_STATUS_CTRL, 8'h00);
    @(negedge clock_i);
    chk("duty_auto", auto_duty, duty);
    alert_en = 1'b1;
    j = $urandom_range(5, 0);
    mgmt_m = 1 << (j + 2);
    fire(6'(1 << j), 6'h00);
    rchk("mgmt_bank", esoc_pkg::ADDR_MGMT_ERR, mgmt_m[7:0]);
    rchk("mgmt_summary", esoc_pkg::ADDR_STATUS_CTRL, 8'h80);
    chk("alert_on", 16'h0001, {15'h0000, alert});
    alert_en = 1'b0;
    repeat (2) @(negedge clock_i);
    chk("alert_off", 16'h0000, {15'h0000, alert});
    esoc_host_model_i.clr(esoc_pkg::ADDR_MGMT_ERR, mgmt_m[7:0]);
    rchk("mgmt_cleared", esoc_pkg::ADDR_MGMT_ERR, 8'h00);
    fire(6'h00, 6'(1 << j));
    rchk("host_bank", esoc_pkg::ADDR_HOST_ERR, mgmt_m[7:0]);
    rchk("host_summary", esoc_pkg::ADDR_STATUS_CTRL, 8'h40);
    esoc_host_model_i.clr(esoc_pkg::ADDR_HOST_ERR, mgmt_m[7:0]);
    // auto-mask by input four, then by input five
    for (int k = 0; k < 2; k++) begin
      esoc_host_model_i.wr(esoc_pkg::ADDR_STATUS_CTRL, 8'(4 << k));
      @(negedge clock_i);
      in_four = (k == 0);
      in_five = (k == 1);
      repeat (4) @(negedge clock_i);
      in_four = 1'b0;
      in_five = 1'b0;
      repeat (5) @(negedge clock_i);
      fire(6'h3f, 6'h3f);
      rchk("mgmt_masked", esoc_pkg::ADDR_MGMT_ERR, 8'(1 << k));
      rchk("host_masked", esoc_pkg::ADDR_HOST_ERR, 8'(1 << k));
      esoc_host_model_i.clr(esoc_pkg::ADDR_MGMT_ERR, 8'(1 << k));
      esoc_host_model_i.clr(esoc_pkg::ADDR_HOST_ERR, 8'(1 << k));
      fire(6'h01, 6'h01);
      rchk("mgmt_released", esoc_pkg::ADDR_MGMT_ERR, 8'h04);
      rchk("host_released", esoc_pkg::ADDR_HOST_ERR, 8'h04);
      esoc_host_model_i.clr(esoc_pkg::ADDR_MGMT_ERR, 8'h04);
      esoc_host_model_i.clr(esoc_pkg::ADDR_HOST_ERR, 8'h04);
    end
    // tach pins toggle at a 160 ns period only inside each burst
    for (int m = 0; m < 4; m++) begin
      esoc_host_model_i.wr(esoc_pkg::ADDR_STATUS_CTRL, 8'(m << 4));
      repeat (2) @(negedge clock_i);
      j = pulses;
      #3;
      repeat (8) #80 tach = ~tach;
      repeat (8) @(negedge clock_i);
      chk("tach_pulses", 16'(tach_exp[m]), 16'(pulses - j));
    end
    esoc_host_model_i.wr(esoc_pkg::ADDR_STATUS_CTRL, 8'h02);
    cfg_lock = 1'b1;
    esoc_host_model_i.wr(esoc_pkg::ADDR_STATUS_CTRL, 8'h00);
    rchk("ctrl_locked", esoc_pkg::ADDR_STATUS_CTRL, 8'h02);
    fire(6'h3f, 6'h00);
    rchk("mgmt_read_clear", esoc_pkg::ADDR_MGMT_ERR, 8'hfc);
    rchk("mgmt_after_read", esoc_pkg::ADDR_MGMT_ERR, 8'h00);
    rchk("summary_after_read", esoc_pkg::ADDR_STATUS_CTRL, 8'h02);
    end_sim();
  end
endmodule : esoc_ctrl_tb
